/* core/rdb_defines.vh */
// constants of the relay driver serial register bank
`ifndef RDB_DEFINES_VH
`define RDB_DEFINES_VH
`define RDB_BIT_WR        15
`define RDB_BIT_WRN       14
`define RDB_PRI_HI        13
`define RDB_PRI_LO        10
`define RDB_SEC_HI        9
`define RDB_SEC_LO        8
`define RDB_PRI_OUT       4'h0
`define RDB_PRI_MAP       4'h1
`define RDB_PRI_DIAG      4'h2
`define RDB_PRI_HW        4'h3
`define RDB_PRI_PG0       4'h4
`define RDB_PRI_PG1       4'h5
`define RDB_SEC_0         2'h0
`define RDB_SEC_1         2'h1
`define RDB_SEC_2         2'h2
`define RDB_SEC_3         2'h3
`define RDB_RST_MAP0      8'h04
`define RDB_RST_MAP1      8'h08
`define RDB_RST_SEL       4'hF
`define RDB_SEL_LOOP      4'hA
`define RDB_SEL_CH_LO     4'h2
`define RDB_SEL_CH_HI     4'h7
`define RDB_HW_ACT        7
`define RDB_HW_RST        6
`define RDB_HW_PAR_MASK   8'h0F
`define RDB_OLON_MASK     8'hFC
`define RDB_FRAME_MIN     16
`define RDB_TER_BIT       7
`define RDB_RST_PG        10'h000
`define RDB_ERR_REPLY     16'h0400
`endif

/* core/rdb_register_bank.v */
// serial register bank of the eight-channel relay driver
`timescale 1ns/1ps
`include "rdb_defines.vh"
module rdb_register_bank #(
  parameter CH = 8
) (
  // system
  input  wire          clock,
  input  wire          sys_rst,
  // serial link pins
  input  wire          link_sclk,
  input  wire          link_cs_n,
  input  wire          link_mosi,
  output reg           link_miso,
  output reg           link_miso_oe,
  // analog status from the power stage
  input  wire [CH-1:0] output_voltage_monitor,
  input  wire [CH-1:0] onstate_openload_flags,
  input  wire [1:0]    input_pin_level,
  // control toward the power stage
  output reg  [CH-1:0] output_switch_control,
  output reg  [CH-1:0] inrush_restart_select,
  output reg  [CH-1:0] input0_channel_map,
  output reg  [CH-1:0] input1_channel_map,
  output reg  [CH-1:0] offstate_diag_current_enable,
  output reg  [3:0]    onstate_openload_select,
  output reg           active_mode_request,
  output reg  [3:0]    parallel_pair_enable,
  output reg  [CH-1:0] fault_latch_clear,
  output reg           device_reset_pulse,
  output reg  [9:0]    pulse_gen0_config,
  output reg  [9:0]    pulse_gen1_config
);

  // synchronisers
  reg [2:0] sclk_sync_reg;
  reg [2:0] cs_sync_reg;
  reg [1:0] mosi_sync_reg;
  reg [CH-1:0] osm_s1_reg;
  reg [CH-1:0] osm_s2_reg;
  reg [CH-1:0] olon_s1_reg;
  reg [CH-1:0] olon_s2_reg;
  reg [1:0] pin_s1_reg;
  reg [1:0] pin_s2_reg;

  // frame state
  reg [15:0] shift_in_reg;
  reg [15:0] shift_out_reg;
  reg [15:0] reply_reg;
  reg [7:0]  bit_count_reg;
  reg        transfer_error_flag;

  // edges of the synchronised link clock and select
  wire cs_active = ~cs_sync_reg[1];
  wire sclk_rise = cs_active & sclk_sync_reg[1] & ~sclk_sync_reg[2];
  wire sclk_fall = cs_active & ~sclk_sync_reg[1] & sclk_sync_reg[2];
  wire cs_start  = ~cs_sync_reg[1] & cs_sync_reg[2];
  wire cs_end    = cs_sync_reg[1] & ~cs_sync_reg[2];

  // frame length legal when 16 + n*8 clocks
  function frame_ok;
    input [7:0] n;
    begin
      frame_ok = (n >= `RDB_FRAME_MIN) && (n[2:0] == 3'h0);
    end
  endfunction

  // last 16 bits shifted in form the command
  wire [15:0] cmd       = shift_in_reg;
  wire        cmd_valid = cmd[`RDB_BIT_WR] ^ cmd[`RDB_BIT_WRN];
  wire        cmd_write = cmd[`RDB_BIT_WR];
  wire [3:0]  pri       = cmd[`RDB_PRI_HI:`RDB_PRI_LO];
  wire [1:0]  sec       = cmd[`RDB_SEC_HI:`RDB_SEC_LO];
  wire [7:0]  wdata     = cmd[7:0];

  // read data of the addressed register
  reg [9:0] rd_data;
  reg       rd_wide;
  always @*
  begin
    rd_data = 10'h000;
    rd_wide = 1'b0;
    case (pri)
      `RDB_PRI_OUT:
      begin
        if (sec == `RDB_SEC_0)
          rd_data = {2'h0, output_switch_control};
        else if (sec == `RDB_SEC_1)
          rd_data = {2'h0, inrush_restart_select};
      end
      `RDB_PRI_MAP:
      begin
        if (sec == `RDB_SEC_0)
          rd_data = {2'h0, input0_channel_map};
        else if (sec == `RDB_SEC_1)
          rd_data = {2'h0, input1_channel_map};
        else if (sec == `RDB_SEC_2)
          rd_data = {2'h0, transfer_error_flag, 5'h00, pin_s2_reg};
      end
      `RDB_PRI_DIAG:
      begin
        if (sec == `RDB_SEC_0)
          rd_data = {2'h0, offstate_diag_current_enable};
        else if (sec == `RDB_SEC_1)
          rd_data = {2'h0, osm_s2_reg};
        else if (sec == `RDB_SEC_2)
          rd_data = {2'h0, olon_s2_reg & `RDB_OLON_MASK};
        else
          rd_data = {6'h00, onstate_openload_select};
      end
      `RDB_PRI_HW:
      begin
        // reset bit and reserved bits read zero
        if (sec == `RDB_SEC_0)
          rd_data = {2'h0, active_mode_request, 3'h0, parallel_pair_enable};
      end
      `RDB_PRI_PG0:
      begin
        rd_data = pulse_gen0_config;
        rd_wide = 1'b1;
      end
      `RDB_PRI_PG1:
      begin
        rd_data = pulse_gen1_config;
        rd_wide = 1'b1;
      end
      default:
        rd_data = 10'h000;
    endcase
  end

  // select field accepts channel, loop and off codes only
  wire sel_legal = ((wdata[3:0] >= `RDB_SEL_CH_LO) && (wdata[3:0] <= `RDB_SEL_CH_HI)) ||
                   (wdata[3:0] == `RDB_SEL_LOOP) || (wdata[3:0] == `RDB_RST_SEL);

  // input synchronisers
  always @(posedge clock)
  begin
    if (sys_rst)
    begin
      sclk_sync_reg <= 3'h0;
      cs_sync_reg   <= 3'h7;
      mosi_sync_reg <= 2'h0;
      osm_s1_reg    <= {CH{1'b0}};
      osm_s2_reg    <= {CH{1'b0}};
      olon_s1_reg   <= {CH{1'b0}};
      olon_s2_reg   <= {CH{1'b0}};
      pin_s1_reg    <= 2'h0;
      pin_s2_reg    <= 2'h0;
    end
    else
    begin
      sclk_sync_reg <= {sclk_sync_reg[1:0], link_sclk};
      cs_sync_reg   <= {cs_sync_reg[1:0], link_cs_n};
      mosi_sync_reg <= {mosi_sync_reg[0], link_mosi};
      osm_s1_reg    <= output_voltage_monitor;
      osm_s2_reg    <= osm_s1_reg;
      olon_s1_reg   <= onstate_openload_flags;
      olon_s2_reg   <= olon_s1_reg;
      pin_s1_reg    <= input_pin_level;
      pin_s2_reg    <= pin_s1_reg;
    end
  end

  // parallel-pair bits of the configuration byte
  wire [7:0] hw_par_bits = wdata & `RDB_HW_PAR_MASK;

  // match of both address fields of a command
  function addr_hit;
    input [3:0] p;
    input [1:0] s;
    input [3:0] want_p;
    input [1:0] want_s;
    begin
      addr_hit = (p == want_p) && (s == want_s);
    end
  endfunction

  // a write commits only at the end of a frame of legal length
  wire wr_commit = cs_end & frame_ok(bit_count_reg) & cmd_valid & cmd_write;

  // per-register write strobes; read-only and unmapped codes get none
  wire wr_out    = wr_commit & addr_hit(pri, sec, `RDB_PRI_OUT, `RDB_SEC_0);
  wire wr_inrush = wr_commit & addr_hit(pri, sec, `RDB_PRI_OUT, `RDB_SEC_1);
  wire wr_map0   = wr_commit & addr_hit(pri, sec, `RDB_PRI_MAP, `RDB_SEC_0);
  wire wr_map1   = wr_commit & addr_hit(pri, sec, `RDB_PRI_MAP, `RDB_SEC_1);
  wire wr_diag   = wr_commit & addr_hit(pri, sec, `RDB_PRI_DIAG, `RDB_SEC_0);
  wire wr_sel    = wr_commit & addr_hit(pri, sec, `RDB_PRI_DIAG, `RDB_SEC_3) & sel_legal;
  wire wr_hw     = wr_commit & addr_hit(pri, sec, `RDB_PRI_HW, `RDB_SEC_0);
  wire wr_clear  = wr_commit & addr_hit(pri, sec, `RDB_PRI_HW, `RDB_SEC_1);
  wire wr_pg0    = wr_commit & (pri == `RDB_PRI_PG0);
  wire wr_pg1    = wr_commit & (pri == `RDB_PRI_PG1);

  // frame engine: shift registers, reply and transfer error
  always @(posedge clock)
  begin
    if (sys_rst || device_reset_pulse)
    begin
      shift_in_reg        <= 16'h0000;
      shift_out_reg       <= 16'h0000;
      reply_reg           <= 16'h0000;
      bit_count_reg       <= 8'h00;
      transfer_error_flag <= 1'b1;
      link_miso           <= 1'b0;
      link_miso_oe        <= 1'b0;
    end
    else
    begin
      link_miso_oe <= cs_active;
      // first reply bit stands before the first link clock edge
      if (cs_start)
      begin
        bit_count_reg <= 8'h00;
        shift_out_reg <= reply_reg;
        link_miso     <= reply_reg[15];
      end
      // counter saturates so overlong frames still count as bad
      if (sclk_rise)
      begin
        shift_in_reg <= {shift_in_reg[14:0], mosi_sync_reg[1]};
        if (bit_count_reg != 8'hFF)
          bit_count_reg <= bit_count_reg + 8'h01;
      end
      if (sclk_fall)
      begin
        shift_out_reg <= {shift_out_reg[14:0], 1'b0};
        link_miso     <= shift_out_reg[14];
      end
      if (cs_end)
      begin
        if (!frame_ok(bit_count_reg))
        begin
          transfer_error_flag <= 1'b1;
          reply_reg           <= `RDB_ERR_REPLY;
        end
        else
        begin
          transfer_error_flag <= 1'b0;
          // answer in next frame carries 10, the primary address field, the secondary field for 8-bit registers only, and the register's read data
          if (rd_wide)
            reply_reg <= {2'b10, pri, rd_data};
          else
            reply_reg <= {2'b10, pri, sec, rd_data[7:0]};
        end
      end
    end
  end

  // output control and inrush behaviour
  always @(posedge clock)
  begin
    if (sys_rst || device_reset_pulse)
    begin
      output_switch_control <= {CH{1'b0}};
      inrush_restart_select <= {CH{1'b0}};
    end
    else
    begin
      if (wr_out)
        output_switch_control <= wdata;
      if (wr_inrush)
        inrush_restart_select <= wdata;
    end
  end

  // input pin channel maps
  always @(posedge clock)
  begin
    if (sys_rst || device_reset_pulse)
    begin
      input0_channel_map <= `RDB_RST_MAP0;
      input1_channel_map <= `RDB_RST_MAP1;
    end
    else
    begin
      if (wr_map0)
        input0_channel_map <= wdata;
      if (wr_map1)
        input1_channel_map <= wdata;
    end
  end

  // off-state diagnostic current and on-state open-load select
  always @(posedge clock)
  begin
    if (sys_rst || device_reset_pulse)
    begin
      offstate_diag_current_enable <= {CH{1'b0}};
      onstate_openload_select      <= `RDB_RST_SEL;
    end
    else
    begin
      if (wr_diag)
        offstate_diag_current_enable <= wdata;
      if (wr_sel)
        onstate_openload_select <= wdata[3:0];
    end
  end

  // hardware configuration and the self-clearing reset command
  always @(posedge clock)
  begin
    if (sys_rst || device_reset_pulse)
    begin
      active_mode_request  <= 1'b0;
      parallel_pair_enable <= 4'h0;
      device_reset_pulse   <= 1'b0;
    end
    else
    begin
      device_reset_pulse <= wr_hw & wdata[`RDB_HW_RST];
      if (wr_hw)
      begin
        active_mode_request  <= wdata[`RDB_HW_ACT];
        parallel_pair_enable <= hw_par_bits[3:0];
      end
    end
  end

  // latch clear is a one-cycle pulse per written bit
  always @(posedge clock)
  begin
    if (sys_rst || device_reset_pulse)
      fault_latch_clear <= {CH{1'b0}};
    else if (wr_clear)
      fault_latch_clear <= wdata;
    else
      fault_latch_clear <= {CH{1'b0}};
  end

  // pulse generator configuration words
  always @(posedge clock)
  begin
    if (sys_rst || device_reset_pulse)
    begin
      pulse_gen0_config <= `RDB_RST_PG;
      pulse_gen1_config <= `RDB_RST_PG;
    end
    else
    begin
      if (wr_pg0)
        pulse_gen0_config <= cmd[9:0];
      if (wr_pg1)
        pulse_gen1_config <= cmd[9:0];
    end
  end

endmodule // rdb_register_bank

/* tb/rdb_register_bank_checker.sv */
// assertions on the ports of the serial register bank
`timescale 1ns/1ps
module rdb_register_bank_checker #(
  parameter CH = 8
) (
  // system
  input wire          clock,
  input wire          sys_rst,
  // serial link
  input wire          link_cs_n,
  input wire          link_miso_oe,
  // control outputs
  input wire [CH-1:0] output_switch_control,
  input wire [CH-1:0] inrush_restart_select,
  input wire [CH-1:0] input0_channel_map,
  input wire [CH-1:0] input1_channel_map,
  input wire [CH-1:0] offstate_diag_current_enable,
  input wire [3:0]    onstate_openload_select,
  input wire          active_mode_request,
  input wire [3:0]    parallel_pair_enable,
  input wire [CH-1:0] fault_latch_clear,
  input wire          device_reset_pulse,
  input wire [9:0]    pulse_gen0_config,
  input wire [9:0]    pulse_gen1_config
);
  default clocking cb @(posedge clock); endclocking
  default disable iff (sys_rst);
  a_reset_cmd_values: assert property (
    device_reset_pulse |=> input0_channel_map == 8'h04 && input1_channel_map == 8'h08
      && onstate_openload_select == 4'hF && !active_mode_request
      && output_switch_control == 8'h00)
    else $error("registers not at reset values after reset command");
  a_reset_pulse_once: assert property (
    device_reset_pulse |=> !device_reset_pulse)
    else $error("reset command pulse longer than one cycle");
  a_select_legal: assert property (
    onstate_openload_select inside {[4'h2:4'h7], 4'hA, 4'hF})
    else $error("open-load select holds a reserved code");
  a_clear_pulse: assert property (
    |fault_latch_clear |-> link_cs_n ##1 fault_latch_clear == 8'h00)
    else $error("latch clear pulse wrong");
  a_mode_in_gap: assert property (
    $changed(active_mode_request) || $changed(parallel_pair_enable) |-> link_cs_n)
    else $error("configuration changed inside a frame");
  a_regs_in_gap: assert property (
    !$stable({output_switch_control, inrush_restart_select, input0_channel_map,
      input1_channel_map, offstate_diag_current_enable, pulse_gen0_config,
      pulse_gen1_config}) |-> link_cs_n)
    else $error("register changed inside a frame");
  a_oe_released: assert property (
    link_cs_n [*6] |-> !link_miso_oe)
    else $error("data out driven while deselected");
  a_oe_in_frame: assert property (
    (!link_cs_n) [*6] |-> link_miso_oe)
    else $error("data out not driven inside a frame");
endmodule // rdb_register_bank_checker
bind rdb_register_bank rdb_register_bank_checker #(.CH(CH)) chk (.*);

/* tb/rdb_host_model.sv */
// serial host model that sends frames to the register bank
`timescale 1ns/1ps
module rdb_host_model (
  // system
  input  wire clock,
  // serial link
  output reg  link_sclk,
  output reg  link_cs_n,
  output reg  link_mosi,
  input  wire link_miso
);
  initial {link_sclk, link_cs_n, link_mosi} = 3'b010;
  // n clocks msb first, last 16 carry the command; random padding before
  task xfer(input [15:0] f, input integer n, output [15:0] r);
    integer i;
    reg [47:0] bits;
    begin
      bits = {$urandom, f};
      r = 16'h0000;
      @(posedge clock) link_cs_n <= 1'b0;
      repeat (4) @(posedge clock);
      for (i = n - 1; i >= 0; i = i - 1)
      begin
        link_mosi <= bits[i];
        repeat (4) @(posedge clock);
        link_sclk <= 1'b1;
        repeat (4) @(posedge clock);
        r = {r[14:0], link_miso};
        link_sclk <= 1'b0;
      end
      repeat (4) @(posedge clock);
      link_cs_n <= 1'b1;
      link_mosi <= ~link_mosi;
      repeat (10) @(posedge clock);
    end
  endtask
endmodule // rdb_host_model

/* tb/testbench.sv */
// self-checking bench for the serial register bank
`timescale 1ns/1ps
module testbench;
  reg         clock, sys_rst;
  reg  [7:0]  output_voltage_monitor, onstate_openload_flags, d, seen_clr;
  reg  [1:0]  input_pin_level;
  wire        link_sclk, link_cs_n, link_mosi, link_miso, link_miso_oe;
  wire [7:0]  output_switch_control, inrush_restart_select, input0_channel_map;
  wire [7:0]  input1_channel_map, offstate_diag_current_enable, fault_latch_clear;
  wire [3:0]  onstate_openload_select, parallel_pair_enable;
  wire        active_mode_request, device_reset_pulse;
  wire [9:0]  pulse_gen0_config, pulse_gen1_config;
  integer     mismatches, checked, i;
  reg  [15:0] r;
  reg  [9:0]  d10;
  reg  [3:0]  cur;
  reg  [7:0]  e [0:5];
  reg  [5:0]  a;
  localparam [35:0] ADDRS = {6'h00, 6'h01, 6'h04, 6'h05, 6'h08, 6'h0C};
  rdb_register_bank uut (.*);
  rdb_host_model host (.*);
  always #50 clock = ~clock;
  always @(posedge clock)
    if (sys_rst)
      seen_clr <= 8'h00;
    else if (|fault_latch_clear)
      seen_clr <= fault_latch_clear;
  function [3:0] exp_sel(input [3:0] old, input [3:0] code);
    exp_sel = (code >= 4'h2 && code <= 4'h7) || code == 4'hA || code == 4'hF ? code : old;
  endfunction
  task chk(input string what, input [15:0] seen, input [15:0] exp);
    begin
      checked = checked + 1;
      if (seen !== exp)
      begin
        mismatches = mismatches + 1;
        $display("[FAIL] %s expected %h seen %h", what, exp, seen);
      end
    end
  endtask
  task wr(input [3:0] p, input [1:0] s, input [7:0] v);
    host.xfer({2'b10, p, s, v}, 16, r);
  endtask
  // read answer arrives during the following frame
  task rdc(input string what, input [3:0] p, input [1:0] s, input [7:0] v);
    begin
      host.xfer({2'b01, p, s, 8'h00}, 16, r);
      host.xfer({2'b01, 4'h1, 2'h2, 8'h00}, 16, r);
      chk(what, r, {2'b10, p, s, v});
    end
  endtask
  task end_of_test;
    begin
      $display("checked %0d mismatches %0d", checked, mismatches);
      if (mismatches == 0 && checked > 0)
        $display("Test passed");
      else
        $display("Test failed");
      $finish;
    end
  endtask
  initial
  begin
    #5_000_000 mismatches = mismatches + 1;
    end_of_test;
  end
  initial
  begin
    clock = 0;
    sys_rst = 1;
    mismatches = 0;
    checked = 0;
    void'($urandom(32'hE9D32CC7));
    repeat (20) @(posedge clock);
    sys_rst <= 1'b0;
    output_voltage_monitor <= 8'($urandom);
    onstate_openload_flags <= 8'($urandom);
    input_pin_level <= 2'($urandom);
    repeat (3) @(posedge clock);
    chk("maps", {input0_channel_map, input1_channel_map}, 16'h0408);
    chk("select", onstate_openload_select, 4'hF);
    chk("out_inrush", {output_switch_control, inrush_restart_select}, 16'h0000);
    chk("diag_hw", {offstate_diag_current_enable, active_mode_request, parallel_pair_enable}, 16'h0000);
    for (i = 0; i < 6; i = i + 1)
    begin
      a = ADDRS[i*6 +: 6];
      d = (i == 0) ? 8'($urandom) & 8'hBF : 8'($urandom);
      wr(a[5:2], a[1:0], d);
      e[i] = (i == 0) ? d & 8'h8F : d;
      rdc("readback", a[5:2], a[1:0], e[i]);
    end
    chk("out", output_switch_control, e[5]);
    chk("inrush", inrush_restart_select, e[4]);
    chk("map1", input1_channel_map, e[2]);
    chk("map0", input0_channel_map, e[3]);
    chk("diag", offstate_diag_current_enable, e[1]);
    chk("hw", {active_mode_request, parallel_pair_enable}, {e[0][7], e[0][3:0]});
    host.xfer({2'b11, 6'h00, ~e[5]}, 16, r);
    host.xfer({2'b00, 6'h00, ~e[5]}, 16, r);
    chk("bad_cmd", output_switch_control, e[5]);
    host.xfer({2'b10, 6'h00, ~e[5]}, 15, r);
    chk("short", output_switch_control, e[5]);
    host.xfer({2'b01, 4'h1, 2'h2, 8'h00}, 16, r);
    chk("err_reply", r, 16'h0400);
    host.xfer({2'b01, 4'h1, 2'h2, 8'h00}, 16, r);
    chk("ter_set", r, {2'b10, 4'h1, 2'h2, 1'b1, 5'h00, input_pin_level});
    rdc("input_status_monitor", 4'h1, 2'h2, {6'h00, input_pin_level});
    host.xfer({2'b10, 6'h00, 8'h5A}, 24, r);
    chk("long", output_switch_control, 8'h5A);
    wr(4'h2, 2'h1, 8'hFF);
    rdc("osm", 4'h2, 2'h1, output_voltage_monitor);
    rdc("olon", 4'h2, 2'h2, onstate_openload_flags & 8'hFC);
    cur = 4'hF;
    for (i = 0; i < 16; i = i + 1)
    begin
      wr(4'h2, 2'h3, {4'($urandom), 4'(i)});
      cur = exp_sel(cur, 4'(i));
      chk("sel", onstate_openload_select, cur);
    end
    rdc("sel_rd", 4'h2, 2'h3, {4'h0, cur});
    d = 8'($urandom) | 8'h01;
    wr(4'h3, 2'h1, d);
    chk("clear", seen_clr, d);
    for (i = 0; i < 2; i = i + 1)
    begin
      d10 = 10'($urandom);
      host.xfer({2'b10, 4'(4 + i), d10}, 16, r);
      chk("pg", i ? pulse_gen1_config : pulse_gen0_config, d10);
      host.xfer({2'b01, 4'(4 + i), 10'h000}, 16, r);
      host.xfer({2'b01, 4'h1, 2'h2, 8'h00}, 16, r);
      chk("pg_rd", r, {2'b10, 4'(4 + i), d10});
    end
    wr(4'h3, 2'h0, 8'hC0);
    chk("soft_rst", {input0_channel_map, output_switch_control}, 16'h0400);
    rdc("hw_rd", 4'h3, 2'h0, 8'h00);
    end_of_test;
  end
endmodule // testbench
